// *** common/ring_coder_pkg.sv ***
/*
  Constants, state codes and CRC helpers of the ring master line coder.
  Assumes LSB-first bit order on the line and a one-bit-per-cycle link clock.
*/
`default_nettype none
package ring_coder_pkg;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int LEN_W = 5;
  localparam logic [7:0] FLAG_BYTE = 8'h7E;
  localparam logic [7:0] FILL_BYTE = 8'h7F;
  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'hFE;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] STUFF_RUN = 3'h5;
  localparam logic [2:0] FLAG_RUN = 3'h6;
  localparam logic [2:0] ABORT_RUN = 3'h7;
  localparam logic [3:0] MIN_FRAME_BYTES = 4'h3;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_RESIDUE = 16'hF0B8;

  typedef enum logic [2:0] {
    TX_FILL = 3'b000,
    TX_OPEN = 3'b001,
    TX_BODY = 3'b010,
    TX_FCS = 3'b011,
    TX_CLOSE = 3'b100,
    TX_ZERO = 3'b101
  } tx_state_e;

  function automatic logic [15:0] crcBit(input logic [15:0] crc, input logic b);
    crcBit = (crc[0] ^ b) ? ((crc >> 1) ^ CRC_POLY) : (crc >> 1);
  endfunction : crcBit

  function automatic logic [15:0] crcByte(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] c;
    c = crc;
    for (int i = 0; i < BYTE_W; i++) begin
      c = crcBit(c, d[i]);
    end
    crcByte = c;
  endfunction : crcByte
endpackage : ring_coder_pkg
`default_nettype wire

// *** logic/ring_line_master.sv ***
/*
  Ring master line coder: transmit FIFO, telegram framer with stuffing, CRC and
  NRZI coding on the link clock, and a receive deframer feeding back to the core.
  Assumes the bench supplies linkClock as the bit clock for both line directions.
*/
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------------------
// Transmit data FIFO
// ----------------------------------------------------------------------------
module ring_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Fill side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // Drain side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic doWrite;
  logic doRead;
  logic [CW-1:0] next_count;

  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;
  assign outValid = (count != '0);
  assign outData = mem[rdPtr];

  always_comb begin
    next_count = count;
    if (doWrite && !doRead) next_count = count + CW'(1);
    if (doRead && !doWrite) next_count = count - CW'(1);
  end

  always_ff @(posedge clock) begin
    if (doWrite) mem[wrPtr] <= inData;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      inReady <= 1'b0;
    end else begin
      if (doWrite) wrPtr <= (wrPtr == PW'(DEPTH-1)) ? '0 : wrPtr + PW'(1);
      if (doRead) rdPtr <= (rdPtr == PW'(DEPTH-1)) ? '0 : rdPtr + PW'(1);
      count <= next_count;
      inReady <= (next_count != CW'(DEPTH));
    end
  end
endmodule : ring_fifo

// ----------------------------------------------------------------------------
// Ring master top
// ----------------------------------------------------------------------------
module ring_line_master (
  // Clocks and reset
  input wire logic clock,
  input wire logic nrst,
  input wire logic linkClock,
  // Payload bytes in
  input wire logic txValid,
  input wire logic [ring_coder_pkg::BYTE_W-1:0] txData,
  output logic txReady,
  // Telegram command
  input wire logic sendStart,
  input wire logic sendSync,
  input wire logic [7:0] sendAddr,
  input wire logic [ring_coder_pkg::LEN_W-1:0] sendLen,
  input wire logic testMode,
  output logic busy,
  output logic cmdRefused,
  output logic cycleStart,
  // Received telegrams
  output logic rxByteValid,
  output logic [7:0] rxByte,
  output logic rxFrameEnd,
  output logic rxFrameGood,
  // Ring pins
  output logic txLine,
  input wire logic rxLine
);
  import ring_coder_pkg::*;

  // --------------------------------------------------------------------------
  // Core domain: FIFO, hold byte, command
  // --------------------------------------------------------------------------
  logic rdValid;
  logic [7:0] rdData;
  logic [LEN_W-1:0] fifoCount;
  logic holdFull;
  logic [7:0] holdByte;
  logic [7:0] cmdAddr;
  logic [LEN_W-1:0] cmdLen;
  logic startToggle;
  logic consumeToggle;
  logic doneToggle;
  logic rxByteToggle;
  logic rxEndToggle;
  logic rxGood;
  logic [7:0] rxByteReg;
  logic [2:0] consumeSync;
  logic [2:0] doneSync;
  logic [2:0] byteSync;
  logic [2:0] endSync;
  logic addrOk;
  logic [LEN_W:0] avail;

  ring_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) txFifo (
    .clock(clock),
    .nrst(nrst),
    .inValid(txValid),
    .inData(txData),
    .inReady(txReady),
    .outValid(rdValid),
    .outData(rdData),
    .outReady(!holdFull),
    .count(fifoCount)
  );

  assign addrOk = (sendAddr >= ADDR_MIN) && (sendAddr <= ADDR_MAX);
  assign avail = {1'b0, fifoCount} + {{LEN_W{1'b0}}, holdFull};

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      consumeSync <= '0;
      doneSync <= '0;
      byteSync <= '0;
      endSync <= '0;
    end else begin
      consumeSync <= {consumeSync[1:0], consumeToggle};
      doneSync <= {doneSync[1:0], doneToggle};
      byteSync <= {byteSync[1:0], rxByteToggle};
      endSync <= {endSync[1:0], rxEndToggle};
    end
  end

  // Hold byte stays still until the link side reports it taken
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      holdFull <= 1'b0;
      holdByte <= '0;
    end else if (consumeSync[2] != consumeSync[1]) begin
      holdFull <= 1'b0;
    end else if (rdValid && !holdFull) begin
      holdFull <= 1'b1;
      holdByte <= rdData;
    end
  end

  // Payload must already be queued: the line cannot pause mid-telegram
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busy <= 1'b0;
      cmdRefused <= 1'b0;
      cycleStart <= 1'b0;
      startToggle <= 1'b0;
      cmdAddr <= '0;
      cmdLen <= '0;
    end else begin
      cmdRefused <= 1'b0;
      cycleStart <= 1'b0;
      if (sendStart && !busy) begin
        if (addrOk && sendLen != '0 && avail >= {1'b0, sendLen}) begin
          busy <= 1'b1;
          cmdAddr <= sendAddr;
          cmdLen <= sendLen;
          startToggle <= ~startToggle;
          cycleStart <= sendSync;
        end else begin
          cmdRefused <= 1'b1;
        end
      end else if (doneSync[2] != doneSync[1]) begin
        busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rxByteValid <= 1'b0;
      rxByte <= '0;
      rxFrameEnd <= 1'b0;
      rxFrameGood <= 1'b0;
    end else begin
      rxByteValid <= byteSync[2] != byteSync[1];
      rxFrameEnd <= endSync[2] != endSync[1];
      if (byteSync[2] != byteSync[1]) rxByte <= rxByteReg;
      if (endSync[2] != endSync[1]) rxFrameGood <= rxGood;
    end
  end

  // --------------------------------------------------------------------------
  // Link domain: transmit framer toward the downstream station
  // --------------------------------------------------------------------------
  tx_state_e txState;
  logic [7:0] curByte;
  logic [2:0] bitIdx;
  logic [2:0] onesCnt;
  logic [15:0] crc;
  logic [7:0] fcsHigh;
  logic fcsSecond;
  logic [LEN_W-1:0] bytesLeft;
  logic [1:0] startSync;
  logic [1:0] testSync;
  logic startSeen;
  logic stuffRegion;
  logic stuffNow;
  logic nextBit;
  logic byteEnd;
  logic [15:0] crcNext;
  logic [15:0] fcsVal;

  assign stuffRegion = (txState == TX_BODY) || (txState == TX_FCS);
  // Check bits may end on five ones: the zero still goes in ahead of the closing flag
  assign stuffNow = (stuffRegion || txState == TX_CLOSE) && (onesCnt == STUFF_RUN);
  assign nextBit = (txState == TX_ZERO) ? 1'b0 : (stuffNow ? 1'b0 : curByte[bitIdx]);
  assign byteEnd = !stuffNow && (bitIdx == LAST_BIT);
  assign crcNext = crcBit(crc, curByte[bitIdx]);
  assign fcsVal = ~crcNext;

  always_ff @(posedge linkClock or negedge nrst) begin
    if (!nrst) begin
      startSync <= '0;
      testSync <= '0;
    end else begin
      startSync <= {startSync[0], startToggle};
      testSync <= {testSync[0], testMode};
    end
  end

  // Line level moves only on the bit clock edge
  always_ff @(posedge linkClock or negedge nrst) begin
    if (!nrst) txLine <= 1'b0;
    else if (!nextBit) txLine <= ~txLine;
  end

  always_ff @(posedge linkClock or negedge nrst) begin
    if (!nrst) begin
      onesCnt <= '0;
      crc <= CRC_INIT;
      bitIdx <= '0;
    end else begin
      if (!stuffRegion || stuffNow || !curByte[bitIdx]) onesCnt <= '0;
      else onesCnt <= onesCnt + 3'h1;
      if (txState == TX_OPEN) crc <= CRC_INIT;
      else if (txState == TX_BODY && !stuffNow) crc <= crcNext;
      if (txState == TX_ZERO) bitIdx <= '0;
      else if (!stuffNow) bitIdx <= bitIdx + 3'h1;
    end
  end

  always_ff @(posedge linkClock or negedge nrst) begin
    if (!nrst) begin
      txState <= TX_FILL;
      curByte <= FILL_BYTE;
      fcsHigh <= '0;
      fcsSecond <= 1'b0;
      bytesLeft <= '0;
      startSeen <= 1'b0;
      consumeToggle <= 1'b0;
      doneToggle <= 1'b0;
    end else if (txState == TX_ZERO) begin
      if (!testSync[1]) begin
        txState <= TX_FILL;
        curByte <= FILL_BYTE;
      end
    end else if (byteEnd) begin
      unique case (txState)
        TX_FILL: begin
          if (testSync[1]) begin
            txState <= TX_ZERO;
          end else if (startSync[1] != startSeen) begin
            txState <= TX_OPEN;
            curByte <= FLAG_BYTE;
          end else begin
            curByte <= FILL_BYTE;
          end
        end
        TX_OPEN: begin
          txState <= TX_BODY;
          curByte <= cmdAddr;
          bytesLeft <= cmdLen;
          startSeen <= startSync[1];
        end
        TX_BODY: begin
          if (bytesLeft != '0) begin
            curByte <= holdByte;
            consumeToggle <= ~consumeToggle;
            bytesLeft <= bytesLeft - LEN_W'(1);
          end else begin
            txState <= TX_FCS;
            curByte <= fcsVal[7:0];
            fcsHigh <= fcsVal[15:8];
            fcsSecond <= 1'b0;
          end
        end
        TX_FCS: begin
          if (!fcsSecond) begin
            fcsSecond <= 1'b1;
            curByte <= fcsHigh;
          end else begin
            txState <= TX_CLOSE;
            curByte <= FLAG_BYTE;
          end
        end
        TX_CLOSE: begin
          txState <= TX_FILL;
          curByte <= FILL_BYTE;
          doneToggle <= ~doneToggle;
        end
        default: begin
          txState <= TX_FILL;
          curByte <= FILL_BYTE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Link domain: receive deframer from the upstream station
  // --------------------------------------------------------------------------
  logic rxS1;
  logic rxS2;
  logic rxPrev;
  logic rxBit;
  logic [2:0] rxOnes;
  logic [7:0] rxShift;
  logic [2:0] rxCnt;
  logic [3:0] rxNum;
  logic [15:0] rxCrc;
  logic inFrame;
  logic rxData;
  logic [7:0] newByte;

  assign rxBit = (rxS2 == rxPrev);
  assign rxData = inFrame && (rxBit ? (rxOnes < FLAG_RUN) : (rxOnes < STUFF_RUN));
  assign newByte = {rxBit, rxShift[7:1]};

  always_ff @(posedge linkClock or negedge nrst) begin
    if (!nrst) begin
      rxS1 <= 1'b0;
      rxS2 <= 1'b0;
      rxPrev <= 1'b0;
    end else begin
      rxS1 <= rxLine;
      rxS2 <= rxS1;
      rxPrev <= rxS2;
    end
  end

  // Flag bits enter the shifter before the flag is seen; CRC only takes whole bytes
  always_ff @(posedge linkClock or negedge nrst) begin
    if (!nrst) begin
      rxOnes <= '0;
      rxShift <= '0;
      rxCnt <= '0;
      rxNum <= '0;
      rxCrc <= CRC_INIT;
      inFrame <= 1'b0;
      rxByteReg <= '0;
      rxByteToggle <= 1'b0;
      rxEndToggle <= 1'b0;
      rxGood <= 1'b0;
    end else begin
      if (rxBit) begin
        if (rxOnes != ABORT_RUN) rxOnes <= rxOnes + 3'h1;
        if (rxOnes == FLAG_RUN) inFrame <= 1'b0;
      end else begin
        rxOnes <= '0;
      end
      if (!rxBit && rxOnes == FLAG_RUN) begin
        if (inFrame && rxNum >= MIN_FRAME_BYTES) begin
          rxEndToggle <= ~rxEndToggle;
          rxGood <= (rxCrc == CRC_RESIDUE) && (rxCnt == LAST_BIT);
        end
        inFrame <= 1'b1;
        rxCnt <= '0;
        rxNum <= '0;
        rxCrc <= CRC_INIT;
      end else if (rxData) begin
        rxShift <= newByte;
        rxCnt <= rxCnt + 3'h1;
        if (rxCnt == LAST_BIT) begin
          rxByteReg <= newByte;
          rxByteToggle <= ~rxByteToggle;
          rxCrc <= crcByte(rxCrc, newByte);
          if (rxNum != 4'hF) rxNum <= rxNum + 4'h1;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  a_stuff_after_five: assert property (@(posedge linkClock) disable iff (!nrst)
    stuffRegion && onesCnt == STUFF_RUN |-> !nextBit ##1 onesCnt == 3'h0)
    else $error("no zero inserted after five ones");
  a_nrzi_toggle: assert property (@(posedge linkClock) disable iff (!nrst)
    1'b1 |=> (txLine != $past(txLine)) == !$past(nextBit))
    else $error("line level does not follow bit value");
  a_fill_shape: assert property (@(posedge linkClock) disable iff (!nrst)
    txState == TX_FILL |-> nextBit == (bitIdx != LAST_BIT))
    else $error("fill pattern wrong");
  a_flag_unstuffed: assert property (@(posedge linkClock) disable iff (!nrst)
    (txState == TX_OPEN || txState == TX_CLOSE) |->
      curByte == FLAG_BYTE && (!stuffNow || (txState == TX_CLOSE && bitIdx == 3'h0)))
    else $error("flag corrupted or stuffed");
  a_test_zeros: assert property (@(posedge linkClock) disable iff (!nrst)
    txState == TX_ZERO |=> txLine != $past(txLine))
    else $error("test stream lacks a transition");
  a_addr_after_flag: assert property (@(posedge linkClock) disable iff (!nrst)
    txState == TX_OPEN && byteEnd |=> txState == TX_BODY && curByte == cmdAddr)
    else $error("address field not after opening flag");
  a_rx_stuff_drop: assert property (@(posedge linkClock) disable iff (!nrst)
    inFrame && !rxBit && rxOnes == STUFF_RUN |=> rxCnt == $past(rxCnt))
    else $error("stuffed zero kept");
  a_addr_range: assert property (@(posedge clock) disable iff (!nrst)
    $rose(busy) |-> $past(sendAddr) >= ADDR_MIN && $past(sendAddr) <= ADDR_MAX)
    else $error("telegram accepted with bad address");
  a_body_to_fcs: assert property (@(posedge linkClock) disable iff (!nrst)
    txState == TX_BODY && byteEnd && bytesLeft == '0 |=> txState == TX_FCS ##[1:20] fcsSecond)
    else $error("check sequence not sent");
  c_sync_sent: cover property (@(posedge clock) disable iff (!nrst) cycleStart);
  c_frame_good: cover property (@(posedge clock) disable iff (!nrst) rxFrameEnd && rxFrameGood);
  c_stuff_seen: cover property (@(posedge linkClock) disable iff (!nrst) stuffNow);
  c_refused: cover property (@(posedge clock) disable iff (!nrst) cmdRefused);
endmodule : ring_line_master
`default_nettype wire

// *** tb/ring_station_model.sv ***
/*
  Neighbour station on the ring: decodes the master's line, keeps the bytes
  it saw and repeats the line level back upstream one bit time later.
  Assumes linkClock is the bit clock of both line directions.
*/
`timescale 1ns/1ns
`default_nettype none

module ring_station_model (
  // Link
  input wire logic linkClock,
  input wire logic txLine,
  output logic rxLine
);
  import ring_coder_pkg::*;

  logic prev = 1'b0;
  logic level = 1'b0;
  logic inFrame = 1'b0;
  logic bitv;
  logic [7:0] raw = 8'h00;
  logic [7:0] cur = 8'h00;
  logic [7:0] gotBytes[$];
  int ones = 0;
  int cnt = 0;
  int zeroRun = 0;
  int fillSeen = 0;
  int offEdge = 0;
  int sameRun = 0;
  int maxSame = 0;
  int armed = 0;
  int flipAt = -1;
  realtime lastEdge = 0;

  // ----------------------------------------------------------------
  // Repeater and edge timing
  // ----------------------------------------------------------------
  always @(posedge linkClock) begin
    lastEdge = $realtime;
    // Never starts a telegram of its own; flipAt spoils one level of that byte
    rxLine <= (gotBytes.size() == flipAt && cnt == 3) ? ~level : level;
  end

  always @(txLine) begin
    if ($realtime > 0 && $realtime != lastEdge) offEdge++;
  end

  // ----------------------------------------------------------------
  // Decoder, sampled mid-bit
  // ----------------------------------------------------------------
  always @(negedge linkClock) begin
    bitv = (txLine === prev);
    prev = txLine;
    level = txLine;
    zeroRun = bitv ? 0 : zeroRun + 1;
    // Longest stretch without an edge that the clock recovery must bridge
    sameRun = bitv ? sameRun + 1 : 0;
    if (!bitv) armed = 1;
    if (armed != 0 && sameRun > maxSame) maxSame = sameRun;
    raw = {bitv, raw[7:1]};
    if (raw == FILL_BYTE) fillSeen++;
    if (raw == FLAG_BYTE) begin
      inFrame = 1'b1;
      cnt = 0;
    end else if (!bitv && ones == 5) begin
      cnt = cnt;
    end else if (inFrame) begin
      cur = {bitv, cur[7:1]};
      cnt++;
      if (cnt == 8) begin
        gotBytes.push_back(cur);
        cnt = 0;
      end
    end
    ones = bitv ? ones + 1 : 0;
    // Seven ones can only be fill: any open frame is dropped
    if (ones == 7) inFrame = 1'b0;
  end
endmodule : ring_station_model

`default_nettype wire

// *** tb/test_ring_line_master.sv ***
/*
  Self-checking bench of the ring master line coder with a looping station.
  Assumes the station repeats the line back into rxLine.
*/
`timescale 1ns/1ns
`default_nettype none

module test_ring_line_master;
  import ring_coder_pkg::*;

  logic clock = 1'b0;
  logic linkClock = 1'b0;
  logic nrst = 1'b0;
  logic txValid = 1'b0;
  logic [7:0] txData = 8'h00;
  logic sendStart = 1'b0;
  logic sendSync = 1'b0;
  logic [7:0] sendAddr = 8'h00;
  logic [4:0] sendLen = 5'h00;
  logic testMode = 1'b0;
  logic txReady, busy, cmdRefused, cycleStart;
  logic rxByteValid, rxFrameEnd, rxFrameGood, txLine, rxLine;
  logic [7:0] rxByte;
  logic [7:0] rxq[$];
  logic rxGood = 1'b0;
  int ends = 0;
  int fail_count = 0;
  int checks_done = 0;

  always #4 clock = ~clock;
  always begin
    #62 linkClock = 1'b1;
    #63 linkClock = 1'b0;
  end

  ring_line_master dut_u (.clock(clock), .nrst(nrst), .linkClock(linkClock),
    .txValid(txValid), .txData(txData), .txReady(txReady), .sendStart(sendStart),
    .sendSync(sendSync), .sendAddr(sendAddr), .sendLen(sendLen), .testMode(testMode),
    .busy(busy), .cmdRefused(cmdRefused), .cycleStart(cycleStart),
    .rxByteValid(rxByteValid), .rxByte(rxByte), .rxFrameEnd(rxFrameEnd),
    .rxFrameGood(rxFrameGood), .txLine(txLine), .rxLine(rxLine));

  ring_station_model ring_u (.linkClock(linkClock), .txLine(txLine), .rxLine(rxLine));

  always @(negedge clock) begin
    if (rxByteValid === 1'b1) rxq.push_back(rxByte);
    if (rxFrameEnd === 1'b1) begin
      ends++;
      rxGood = rxFrameGood;
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  function automatic logic [15:0] fcs_of(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i]) for (int k = 0; k < 8; k++) c = (c[0] ^ b[i][k]) ? (c >> 1) ^ 16'h8408 : c >> 1;
    return ~c;
  endfunction : fcs_of

  task automatic push_all(input logic [7:0] p[$]);
    @(posedge clock);
    foreach (p[i]) begin
      txData <= p[i];
      txValid <= 1'b1;
      @(negedge clock);
      while (txReady !== 1'b1) @(negedge clock);
      @(posedge clock);
    end
    txValid <= 1'b0;
  endtask : push_all

  task automatic send(input logic [7:0] a, input logic [4:0] len, input logic sync,
                      input logic refused);
    repeat (2) @(posedge clock);
    sendStart <= 1'b1;
    sendAddr <= a;
    sendLen <= len;
    sendSync <= sync;
    @(posedge clock);
    sendStart <= 1'b0;
    @(negedge clock);
    check(16'(cmdRefused), 16'(refused));
    check(16'(busy), 16'(!refused));
    check(16'(cycleStart), 16'(sync && !refused));
  endtask : send

  // Line copy must match; looped-back copy must match too, except byte 2 of a spoilt frame
  task automatic expect_frame(input logic [7:0] a, input logic [7:0] p[$], input logic good);
    logic [7:0] e[$];
    logic [15:0] f;
    int n;
    int e0;
    e = p;
    e.push_front(a);
    f = fcs_of(e);
    e.push_back(f[7:0]);
    e.push_back(f[15:8]);
    e0 = ends;
    n = 0;
    while ((busy !== 1'b0 || ends == e0) && n < 9000) begin
      @(negedge clock);
      n++;
    end
    check(16'(ring_u.gotBytes.size()), 16'(e.size()));
    check(16'(rxq.size()), 16'(e.size()));
    check(16'(rxGood), 16'(good));
    foreach (e[i]) begin
      check(16'(ring_u.gotBytes[i]), 16'(e[i]));
      if (good || i != 2) check(16'(rxq[i]), 16'(e[i]));
      else check(16'(rxq[i] ^ e[i]), 16'h000C);
    end
    ring_u.gotBytes.delete();
    rxq.delete();
  endtask : expect_frame

  task automatic frame(input logic [7:0] a, input logic sync, input logic [7:0] p[$]);
    push_all(p);
    send(a, 5'(p.size()), sync, 1'b0);
    expect_frame(a, p, 1'b1);
  endtask : frame

  // One spoilt line level flips two decoded bits and must fail the check sequence
  task automatic bad_frame();
    ring_u.flipAt = 2;
    push_all({8'h00, 8'h00, 8'h00});
    send(8'h21, 5'h03, 1'b0, 1'b0);
    expect_frame(8'h21, {8'h00, 8'h00, 8'h00}, 1'b0);
    ring_u.flipAt = -1;
  endtask : bad_frame

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic refusals();
    push_all({8'ha5, 8'h3c});
    send(8'h00, 5'h01, 1'b0, 1'b1);
    send(8'hff, 5'h01, 1'b1, 1'b1);
    send(8'h05, 5'h00, 1'b0, 1'b1);
    send(8'h05, 5'h03, 1'b0, 1'b1);
    send(8'h33, 5'h02, 1'b0, 1'b0);
    expect_frame(8'h33, {8'ha5, 8'h3c}, 1'b1);
  endtask : refusals

  task automatic full_fifo();
    logic [7:0] p[$];
    int k;
    k = 0;
    @(posedge clock);
    while (k < 20) begin
      txData <= 8'(k);
      txValid <= 1'b1;
      @(negedge clock);
      if (txReady !== 1'b1) break;
      @(posedge clock);
      k++;
    end
    @(posedge clock);
    txValid <= 1'b0;
    check(16'(k), 16'h0011);
    for (int i = 0; i < 16; i++) p.push_back(8'(i));
    send(ADDR_MAX, 5'h10, 1'b0, 1'b0);
    expect_frame(ADDR_MAX, p, 1'b1);
    send(8'h80, 5'h01, 1'b1, 1'b0);
    expect_frame(8'h80, {8'h10}, 1'b1);
    send(8'h80, 5'h01, 1'b0, 1'b1);
  endtask : full_fifo

  task automatic idle_test();
    int f0;
    int e0;
    f0 = ring_u.fillSeen;
    e0 = ends;
    repeat (400) @(posedge clock);
    check(16'(ring_u.fillSeen - f0 >= 2), 16'h0001);
    testMode <= 1'b1;
    repeat (1500) @(posedge clock);
    check(16'(ring_u.zeroRun >= 60), 16'h0001);
    testMode <= 1'b0;
    f0 = ring_u.fillSeen;
    repeat (800) @(posedge clock);
    check(16'(ring_u.fillSeen - f0 >= 3), 16'h0001);
    check(16'(ends - e0), 16'h0000);
  endtask : idle_test

  initial begin
    // Link side needs two of its own edges inside reset
    repeat (8) @(posedge clock);
    repeat (2) @(posedge linkClock);
    @(negedge clock);
    check(16'(txReady), 16'h0000);
    @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    @(negedge clock);
    check(16'(txReady), 16'h0001);
    check(16'(busy), 16'h0000);
    frame(ADDR_MIN, 1'b1, {8'hff, 8'h7e, 8'h00, 8'hff});
    frame(8'h02, 1'b0, {8'hf8, 8'h1f, 8'hfc});
    refusals();
    bad_frame();
    full_fifo();
    idle_test();
    check(16'(ring_u.offEdge), 16'h0000);
    check(16'(ring_u.maxSame <= 7), 16'h0001);
    print_verdict();
  end

  initial begin
    #700000;
    fail_count++;
    print_verdict();
  end
endmodule : test_ring_line_master

`default_nettype wire
